// ===== logic/csf_pkg.sv
// Package holding constants and carrier types of the shared-resource fabric.
package csf_pkg;
    // =====================================================================
    // Sizes.
    localparam int unsigned NUM_CORES = 8;
    localparam int unsigned PIN_COUNT = 32;
    localparam int unsigned WORD_W    = 32;
    localparam int unsigned CORE_W    = 3;
    localparam int unsigned SPR_IDX_W = 4;
    localparam int unsigned LOC_W     = 9;

    // =====================================================================
    // Special register locations inside a core's register space.
    localparam logic [LOC_W-1:0] SPR_BASE_LOC      = 9'h1f0;
    localparam logic [LOC_W-1:0] SPR_LAST_LOC      = 9'h1ff;
    localparam logic [SPR_IDX_W-1:0] IDX_TICK      = 4'h1;
    localparam logic [SPR_IDX_W-1:0] IDX_PIN_IN    = 4'h2;
    localparam logic [SPR_IDX_W-1:0] IDX_PIN_OUT   = 4'h4;
    localparam logic [SPR_IDX_W-1:0] IDX_PIN_DIR   = 4'h6;
    localparam logic [LOC_W-1:0] LOC_PIN_OUT       = 9'h1f4;

    // =====================================================================
    // Timing of the access sequencer, in system clock cycles.
    localparam int unsigned SEQ_DIV        = 2;
    localparam int unsigned WINDOW_PERIOD  = SEQ_DIV * NUM_CORES;
    localparam int unsigned HUB_EXEC_CYC   = 7;
    localparam int unsigned MAX_SYNC_CYC   = WINDOW_PERIOD - 1;
    localparam int unsigned MAX_TOTAL_CYC  = MAX_SYNC_CYC + HUB_EXEC_CYC;
    localparam logic [2:0]  EXEC_LAST      = 3'h6;
    localparam logic [WORD_W-1:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [WORD_W-1:0] TICK_STEP = 32'h0000_0001;

    // =====================================================================
    // Carrier types.
    typedef logic [WORD_W-1:0] csf_word_t;

    // Register access from one core.
    typedef struct packed {
        logic                 wrEn;
        logic                 byIndex;
        logic [SPR_IDX_W-1:0] index;
        logic [LOC_W-1:0]     loc;
        csf_word_t            wrData;
    } csf_reg_req_s;

    // Per-core pin view presented to the combiner.
    typedef struct packed {
        csf_word_t dir;
        csf_word_t out;
    } csf_pin_drive_s;

    typedef enum logic [1:0] {
        HUB_IDLE,
        HUB_WAIT,
        HUB_EXEC
    } csf_hub_e;
endpackage

// ===== logic/csf_fabric.sv
// Shared-resource fabric: access sequencer, wired-OR pin combiner, system counter.
//
// Notes on behaviour
// - Special registers by address, name, or index.
// - Sequencer grants one core, 0 to 7 wrapping.
// - Sequencer at half clock; window every 16.
// - Hub operation waits <=15, executes 7 cycles.
// - Adjacent core windows are two cycles apart.
// - One core's hub operations never stall others.
// - Ordinary instructions four cycles; two fit between.
// - Thirty-two pins usable by any core anytime.
// - Each core owns direction/output; directions ORed.
// - Contribution is (out OR peripheral) AND direction.
// - Pin input unless driven; high if any high.
// - Direction bit one means output, zero input.
// - Stopped core's direction and outputs forced zero.
// - Input sample reads live pins, any direction.
// - Global read-only counter increments every clock.
// - All cores read the counter simultaneously.
// - Counter is not cleared at startup.
// - Sequencer rotates whether or not cores run.
// - Special locations 500 and 502 (output, direction) cleared on core start.
`timescale 1ns/1ps

module csf_fabric
    import csf_pkg::*;
(
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    input  wire logic [NUM_CORES-1:0]           coreRun,
    input  wire logic [NUM_CORES-1:0]           coreStart,
    input  wire csf_reg_req_s [NUM_CORES-1:0]   regReq,
    input  wire logic [NUM_CORES-1:0]           hubReq,
    input  wire csf_word_t [NUM_CORES-1:0]      periphOut,
    input  wire csf_word_t                      pinIn,
    output csf_word_t [NUM_CORES-1:0]           regRdData,
    output logic [NUM_CORES-1:0]                hubBusy,
    output logic [NUM_CORES-1:0]                hubDone,
    output logic [CORE_W-1:0]                   grantCore,
    output logic                                grantWindow,
    output csf_word_t                           pinOut,
    output csf_word_t                           pinOe
);

    // =====================================================================
    // System counter.
    // Power-up value is arbitrary; only differences between readings mean anything.
    csf_word_t tickCount = ZERO_WORD;

    // Free-running, with no reset term so its value at power-up is left as is.
    always_ff @(posedge clk)
    begin
        tickCount <= tickCount + TICK_STEP;
    end

    // =====================================================================
    // Access sequencer.
    logic             seqPhase;
    logic [CORE_W-1:0] seqSlot;

    // Half-rate enable; slot advances every other cycle regardless of run state.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seqPhase <= 1'b0;
            seqSlot  <= '0;
        end
        else
        begin
            seqPhase <= ~seqPhase;
            if (seqPhase)
                seqSlot <= seqSlot + 3'h1;
        end
    end

    // Window opens on the first cycle of a slot.
    logic [NUM_CORES-1:0] windowNow;
    always_comb
    begin
        windowNow = '0;
        windowNow[seqSlot] = ~seqPhase;
    end

    // Registered grant outputs for observation.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            grantCore   <= '0;
            grantWindow <= 1'b0;
        end
        else
        begin
            grantCore   <= seqSlot;
            grantWindow <= ~seqPhase;
        end
    end

    // =====================================================================
    // Per-core register files and hub handshake.
    csf_word_t [NUM_CORES-1:0] dirWord;
    csf_word_t [NUM_CORES-1:0] outWord;
    csf_word_t                 pinSync1;
    csf_word_t                 pinSync2;

    // Pins arrive from outside; two flops before any read.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pinSync1 <= ZERO_WORD;
            pinSync2 <= ZERO_WORD;
        end
        else
        begin
            pinSync1 <= pinIn;
            pinSync2 <= pinSync1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CORES; g++)
        begin : gCore
            logic [SPR_IDX_W-1:0] idx;
            logic                 isSpr;
            csf_hub_e             hubState;
            logic [2:0]           execCnt;
            logic                 stopped;

            // Address by location or by array index; both map to one index.
            always_comb
            begin
                idx   = regReq[g].byIndex ? regReq[g].index
                                          : regReq[g].loc[SPR_IDX_W-1:0];
                isSpr = regReq[g].byIndex || (regReq[g].loc >= SPR_BASE_LOC);
            end

            assign stopped = ~coreRun[g] | coreStart[g];

            // Direction and output words; cleared on stop and on start.
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    dirWord[g] <= ZERO_WORD;
                    outWord[g] <= ZERO_WORD;
                end
                else if (stopped)
                begin
                    dirWord[g] <= ZERO_WORD;
                    outWord[g] <= ZERO_WORD;
                end
                else if (regReq[g].wrEn && isSpr)
                begin
                    if (idx == IDX_PIN_DIR)
                        dirWord[g] <= regReq[g].wrData;
                    if (idx == IDX_PIN_OUT)
                        outWord[g] <= regReq[g].wrData;
                end
            end

            // Reads: counter and pins need no sequencer slot.
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    regRdData[g] <= ZERO_WORD;
                else if (!isSpr)
                    regRdData[g] <= ZERO_WORD;
                else
                begin
                    case (idx)
                        IDX_TICK:    regRdData[g] <= tickCount;
                        IDX_PIN_IN:  regRdData[g] <= pinSync2;
                        IDX_PIN_OUT: regRdData[g] <= outWord[g];
                        IDX_PIN_DIR: regRdData[g] <= dirWord[g];
                        default:     regRdData[g] <= ZERO_WORD;
                    endcase
                end
            end

            // Hub operation: wait for own window, then seven cycles.
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    hubState   <= HUB_IDLE;
                    execCnt    <= '0;
                    hubBusy[g] <= 1'b0;
                    hubDone[g] <= 1'b0;
                end
                else
                begin
                    hubDone[g] <= 1'b0;
                    case (hubState)
                        HUB_IDLE:
                        begin
                            if (hubReq[g] && coreRun[g])
                            begin
                                hubBusy[g] <= 1'b1;
                                hubState   <= windowNow[g] ? HUB_EXEC : HUB_WAIT;
                                execCnt    <= windowNow[g] ? 3'h1 : 3'h0;
                            end
                        end
                        HUB_WAIT:
                        begin
                            if (windowNow[g])
                            begin
                                hubState <= HUB_EXEC;
                                execCnt  <= 3'h1;
                            end
                        end
                        HUB_EXEC:
                        begin
                            if (execCnt == EXEC_LAST)
                            begin
                                hubState   <= HUB_IDLE;
                                hubBusy[g] <= 1'b0;
                                hubDone[g] <= 1'b1;
                            end
                            else
                                execCnt <= execCnt + 3'h1;
                        end
                        default:
                            hubState <= HUB_IDLE;
                    endcase
                end
            end
        end
    endgenerate

    // =====================================================================
    // Wired-OR pin combiner.
    csf_word_t next_pinOe;
    csf_word_t next_pinOut;

    // Each active core contributes; stopped cores contribute nothing.
    always_comb
    begin
        next_pinOe  = ZERO_WORD;
        next_pinOut = ZERO_WORD;
        for (int i = 0; i < NUM_CORES; i++)
        begin
            if (coreRun[i])
            begin
                next_pinOe  = next_pinOe | dirWord[i];
                next_pinOut = next_pinOut
                            | ((outWord[i] | periphOut[i]) & dirWord[i]);
            end
        end
    end

    // Registered pin drive; undriven bits are inputs.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pinOe  <= ZERO_WORD;
            pinOut <= ZERO_WORD;
        end
        else
        begin
            pinOe  <= next_pinOe;
            pinOut <= next_pinOut;
        end
    end

    // =====================================================================
    // Assertions.
    // Core 0 reading its input sample, used by the sample check below.
    logic isIn0;
    assign isIn0 = gCore[0].isSpr && gCore[0].idx == IDX_PIN_IN;

    sequence slotStepS;
        seqPhase ##1 !seqPhase;
    endsequence

    property slotRotateP;
        @(posedge clk) disable iff (!rst_n)
        (seqPhase && seqSlot == 3'h7) |=> (seqSlot == 3'h0);
    endproperty
    slot_wrap_a: assert property (slotRotateP) else $error("slot did not wrap");

    slot_advance_a: assert property (@(posedge clk) disable iff (!rst_n)
        slotStepS |-> seqSlot == $past(seqSlot) + 3'h1) else $error("slot step");

    half_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
        !seqPhase |=> seqPhase && $stable(seqSlot)) else $error("rate wrong");

    window_period_a: assert property (@(posedge clk) disable iff (!rst_n)
        windowNow[0] |-> ##16 windowNow[0]) else $error("period wrong");

    // Disabled in reset so that the first comparison has a settled previous value.
    tick_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        tickCount == $past(tickCount) + TICK_STEP) else $error("counter step");

    // Busy rises at the taking edge and $rose sees it one edge later, so 7 to 22 becomes 6 to 21 here.
    hub_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
        ($rose(hubBusy[0]) && coreRun[0]) |-> ##[6:21] hubDone[0])
        else $error("hub time");

    // Core 3 is the one t_stop_start stops, so it is the one watched.
    stop_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        !coreRun[3] |=> dirWord[3] == ZERO_WORD && outWord[3] == ZERO_WORD)
        else $error("stop clear");

    pin_or_a: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> pinOe == $past(next_pinOe) && (pinOut & ~pinOe) == ZERO_WORD)
        else $error("pin combine");

    pin_sample_a: assert property (@(posedge clk) disable iff (!rst_n)
        (isIn0) |=> regRdData[0] == $past(pinSync2)) else $error("input sample");

    // Only one core may hold the window in any cycle.
    window_one_a: assert property (@(posedge clk) disable iff (!rst_n)
        $onehot0(windowNow)) else $error("two windows");

    // A request that lands in its own window runs six busy cycles, then done.
    // No wait state may be inserted in that case.
    sequence hubTakeNowS;
        gCore[0].hubState == HUB_IDLE && hubReq[0] && coreRun[0] && windowNow[0];
    endsequence

    sequence hubBodyS;
        hubBusy[0] [*6] ##1 hubDone[0];
    endsequence

    hub_best_a: assert property (@(posedge clk) disable iff (!rst_n)
        hubTakeNowS |=> hubBodyS) else $error("hub best case");

    // Starting a core wipes its pin words even if it was running before.
    start_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        coreStart[4] |=> dirWord[4] == ZERO_WORD && outWord[4] == ZERO_WORD)
        else $error("start clear");

    // Counter reads need no window: the value of the request cycle comes back.
    tick_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        (gCore[1].isSpr && gCore[1].idx == IDX_TICK)
        |=> regRdData[1] == $past(tickCount))
        else $error("counter read");

endmodule // csf_fabric

// ===== tb/csf_core_model.sv
// Behavioural model of the eight cores and the pad ring around the fabric.
`timescale 1ns/1ps

module csf_core_model
    import csf_pkg::*;
(
    input  wire logic                      clk,
    input  wire csf_word_t [NUM_CORES-1:0] regRdData,
    input  wire logic [NUM_CORES-1:0]      hubDone,
    input  wire csf_word_t                 pinOut,
    input  wire csf_word_t                 pinOe,
    output logic [NUM_CORES-1:0]           coreRun,
    output logic [NUM_CORES-1:0]           coreStart,
    output csf_reg_req_s [NUM_CORES-1:0]   regReq,
    output logic [NUM_CORES-1:0]           hubReq,
    output csf_word_t [NUM_CORES-1:0]      periphOut,
    output csf_word_t                      pinIn
);
    // =====================================================================
    // Pads: a driven pin shows the fabric's level, an undriven one the outside level.
    csf_word_t extLevel;
    assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);

    // All cores start running with quiet requests.
    initial
    begin
        coreRun = '1;
        coreStart = '0;
        regReq = '0;
        hubReq = '0;
        periphOut = '0;
        extLevel = 32'h0000_0000;
    end

    // =====================================================================
    // One register access; read data is taken one edge after the request.
    task automatic access(input int c, input logic wr, input logic byIdx,
                          input logic [LOC_W-1:0] key, input csf_word_t data,
                          output csf_word_t rd);
        csf_reg_req_s r;
        r.wrEn = wr;
        r.byIndex = byIdx;
        r.index = key[SPR_IDX_W-1:0];
        r.loc = key;
        r.wrData = data;
        @(posedge clk);
        #1;
        regReq[c] = r;
        @(posedge clk);
        #1;
        rd = regRdData[c];
        regReq[c] = '0;
    endtask

    // A hub operation; the count includes the edge that takes the request.
    task automatic hub_op(input int c, output int cyc);
        @(posedge clk);
        #1;
        hubReq[c] = 1'b1;
        @(posedge clk);
        #1;
        hubReq[c] = 1'b0;
        cyc = 1;
        while (hubDone[c] !== 1'b1 && cyc < 40)
        begin
            @(posedge clk);
            #1;
            cyc++;
        end
    endtask
endmodule // csf_core_model

// ===== tb/csf_fabric_test.sv
// Self-checking testbench of the shared-resource fabric.
`timescale 1ns/1ps

module csf_fabric_test
    import csf_pkg::*;
;
    // =====================================================================
    // Signals and expectations.
    logic                           clk;
    logic                           rst_n;
    logic [NUM_CORES-1:0]           coreRun, coreStart, hubReq, hubBusy, hubDone;
    csf_reg_req_s [NUM_CORES-1:0]   regReq;
    csf_word_t [NUM_CORES-1:0]      periphOut, regRdData;
    csf_word_t                      pinIn, pinOut, pinOe, rd, expOe, expPo;
    logic [CORE_W-1:0]              grantCore;
    logic                           grantWindow;
    csf_word_t                      eDir [NUM_CORES];
    csf_word_t                      eOut [NUM_CORES];
    logic [NUM_CORES-1:0]           eRun;
    int                             nFail, checksDone;

    csf_fabric i_csf_fabric (.clk(clk), .rst_n(rst_n), .coreRun(coreRun),
        .coreStart(coreStart), .regReq(regReq), .hubReq(hubReq), .periphOut(periphOut),
        .pinIn(pinIn), .regRdData(regRdData), .hubBusy(hubBusy), .hubDone(hubDone),
        .grantCore(grantCore), .grantWindow(grantWindow), .pinOut(pinOut), .pinOe(pinOe));

    csf_core_model i_csf_core_model (.clk(clk), .regRdData(regRdData), .hubDone(hubDone),
        .pinOut(pinOut), .pinOe(pinOe), .coreRun(coreRun), .coreStart(coreStart),
        .regReq(regReq), .hubReq(hubReq), .periphOut(periphOut), .pinIn(pinIn));

    // =====================================================================
    // Shared helpers.
    task automatic check(input string what, input csf_word_t exp, input csf_word_t got);
        checksDone++;
        if (got !== exp)
        begin
            nFail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bounded wait for the delayed window flag of one core.
    task automatic wait_grant(input logic [CORE_W-1:0] k);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end while (!(grantWindow === 1'b1 && grantCore === k) && n < 40);
        check("grant seen", 32'h1, csf_word_t'(grantWindow === 1'b1 && grantCore === k));
    endtask

    task automatic set_core(input int c, input csf_word_t dir, input csf_word_t out);
        i_csf_core_model.access(c, 1'b1, 1'b0, LOC_PIN_OUT, out, rd);
        i_csf_core_model.access(c, 1'b1, 1'b1, {5'h00, IDX_PIN_DIR}, dir, rd);
        eDir[c] = dir;
        eOut[c] = out;
    endtask

    // The wired-OR is rebuilt here from the words each running core holds.
    task automatic check_pins();
        expOe = '0;
        expPo = '0;
        repeat (3) @(posedge clk);
        #1;
        for (int c = 0; c < NUM_CORES; c++)
        begin
            if (eRun[c])
            begin
                expOe |= eDir[c];
                expPo |= (eOut[c] | periphOut[c]) & eDir[c];
            end
        end
        check("pin enable", expOe, pinOe);
        check("pin level", expPo, pinOut);
    endtask

    // =====================================================================
    // Scenarios.
    task automatic t_rotation();
        logic [CORE_W-1:0] prev;
        logic [CORE_W-1:0] nxt;
        int gap;
        i_csf_core_model.coreRun = 8'h0f;
        wait_grant(3'h7);
        prev = 3'h7;
        repeat (NUM_CORES + 1)
        begin
            gap = 0;
            do
            begin
                @(posedge clk);
                #1;
                gap++;
            end while (grantWindow !== 1'b1 && gap < 40);
            nxt = prev + 3'h1;
            check("slot", csf_word_t'(nxt), csf_word_t'(grantCore));
            check("slot gap", SEQ_DIV, gap);
            prev = grantCore;
        end
        i_csf_core_model.coreRun = 8'hff;
    endtask

    // Sweeping the request over all sixteen phases spans best and worst case.
    task automatic t_hub_sweep();
        int cyc, lo, hi;
        lo = 99;
        hi = 0;
        for (int d = 0; d < WINDOW_PERIOD; d++)
        begin
            wait_grant(3'h0);
            repeat (d) @(posedge clk);
            i_csf_core_model.hub_op(0, cyc);
            lo = (cyc < lo) ? cyc : lo;
            hi = (cyc > hi) ? cyc : hi;
        end
        check("hub best", HUB_EXEC_CYC, lo);
        check("hub worst", MAX_TOTAL_CYC, hi);
    endtask

    task automatic t_all_hub();
        int cyc [NUM_CORES];
        for (int c = 0; c < NUM_CORES; c++)
        begin
            fork
                automatic int k = c;
                i_csf_core_model.hub_op(k, cyc[k]);
            join_none
        end
        wait fork;
        for (int c = 0; c < NUM_CORES; c++)
            check("hub together", 32'h1, csf_word_t'(cyc[c] <= MAX_TOTAL_CYC));
    endtask

    // Bit 12 cases: high byte holds each core's direction, low byte its output.
    task automatic t_pins();
        logic [15:0] rows [6] = '{16'h0100, 16'h0101, 16'h0102, 16'h0302, 16'hf708, 16'hff08};
        i_csf_core_model.periphOut[5] = 32'h0000_00f0;
        foreach (rows[r])
        begin
            for (int c = 0; c < NUM_CORES; c++)
                set_core(c, csf_word_t'(rows[r][8+c]) << 12, csf_word_t'(rows[r][c]) << 12);
            check_pins();
        end
        set_core(5, 32'h0000_1030, 32'h0000_0000);
        check_pins();
        i_csf_core_model.access(3, 1'b0, 1'b1, {5'h00, IDX_PIN_OUT}, '0, rd);
        check("out by index", eOut[3], rd);
        i_csf_core_model.access(5, 1'b0, 1'b0, LOC_PIN_OUT + 9'h002, '0, rd);
        check("dir by place", eDir[5], rd);
    endtask

    // Stopping a core removes it; starting it clears its words.
    task automatic t_stop_start();
        @(posedge clk);
        #1;
        i_csf_core_model.coreRun[3] = 1'b0;
        eRun[3] = 1'b0;
        check_pins();
        i_csf_core_model.coreStart[3] = 1'b1;
        @(posedge clk);
        #1;
        i_csf_core_model.coreStart[3] = 1'b0;
        i_csf_core_model.coreRun[3] = 1'b1;
        eRun[3] = 1'b1;
        eDir[3] = '0;
        eOut[3] = '0;
        check_pins();
        i_csf_core_model.access(3, 1'b0, 1'b1, {5'h00, IDX_PIN_DIR}, '0, rd);
        check("dir after start", 32'h0, rd);
    endtask

    task automatic t_input();
        csf_word_t ext;
        ext = 32'h5a5a_c3c3;
        i_csf_core_model.extLevel = ext;
        repeat (4) @(posedge clk);
        i_csf_core_model.access(0, 1'b0, 1'b1, {5'h00, IDX_PIN_IN}, '0, rd);
        check("pin sample", (expOe & expPo) | (~expOe & ext), rd);
    endtask

    // Two four-cycle instructions fit between hub operations; the counter is shared.
    task automatic t_pace_tick();
        int cyc;
        csf_word_t t0, t1, t2;
        wait_grant(3'h0);
        repeat (14) @(posedge clk);
        fork
            i_csf_core_model.hub_op(0, cyc);
            begin
                repeat (3) @(posedge clk);
                #1;
                check("hub busy", 32'h1, csf_word_t'(hubBusy));
            end
        join
        check("hub idle", 32'h0, csf_word_t'(hubBusy));
        repeat (2 * 4) @(posedge clk);
        i_csf_core_model.hub_op(0, cyc);
        check("hub paced", HUB_EXEC_CYC, cyc);
        i_csf_core_model.access(0, 1'b0, 1'b0, SPR_BASE_LOC + 9'h001, '0, t0);
        i_csf_core_model.coreStart[4] = 1'b1;
        fork
            i_csf_core_model.access(1, 1'b0, 1'b1, {5'h00, IDX_TICK}, '0, t1);
            i_csf_core_model.access(2, 1'b0, 1'b1, {5'h00, IDX_TICK}, '0, t2);
        join
        i_csf_core_model.coreStart[4] = 1'b0;
        check("tick step", 32'h2, t1 - t0);
        check("tick shared", 32'h2, t2 - t0);
    endtask

    // =====================================================================
    // Clock, reset, sequence, verdict and watchdog.
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial
    begin
        nFail = 0;
        checksDone = 0;
        eRun = '1;
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_rotation();
        t_hub_sweep();
        t_all_hub();
        t_pins();
        t_stop_start();
        t_input();
        t_pace_tick();
        wrap_up();
    end

    // The run needs about a thousand cycles; twenty thousand means a hang.
    initial
    begin
        #(40 * 20000);
        nFail++;
        wrap_up();
    end
endmodule // csf_fabric_test
